/* File: irqrec_top.sv */
// Interrupt request recognition: pins and module requests to the core
`include "irqrec_consts.svh"
module irqrec_top
   import irqrec_pkg::*;
#(
   parameter int LEVELS = `IRQREC_LEVELS
) (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_b_i,
   // External pins, active low, input only
   input  wire logic              level_six_request_pin_b_i,
   input  wire logic              nonmaskable_request_pin_b_i,
   // Internal module requests, active low, bit n is level n+1
   input  wire logic [LEVELS-1:0] lowest_level_request_b_i,
   // Core handshake
   input  wire logic              boundary_i,
   input  wire logic              ack_done_i,
   input  wire logic              mask_wr_i,
   input  wire irqrec_lvl_t       mask_wr_val_i,
   // To core
   output logic                   pending_o,
   output irqrec_lvl_t            pending_lvl_o,
   output logic                   ack_active_o,
   output logic [3:1]             ack_addr_o,
   output irqrec_vec_t            autovec_o,
   output logic [7:0]             condition_code_register_o,
   output irqrec_lvl_t            priority_mask_field_o
);
   irqrec_req_if req ();

   irqrec_state_t      state_q;
   irqrec_state_t      state_d;
   irqrec_lvl_t        mask_q;
   irqrec_lvl_t        mask_d;
   irqrec_lvl_t        ack_lvl_q;
   logic [LEVELS-1:0]  int_hist0_q;
   logic [LEVELS-1:0]  int_hist1_q;
   logic               nmi_latch_q;
   logic               nmi_latch_d;
   logic               int7_seen_q;
   wire [4:0]          cc_low;

   wire [LEVELS-1:0]   int_valid;
   wire [LEVELS-1:0]   merged;
   wire [LEVELS-1:0]   unmasked;
   wire                nmi_mask_drop;
   wire                nmi_set;
   wire                take;
   wire irqrec_lvl_t   best_lvl;
   wire irqrec_lvl_t   new_mask;
   wire                int7_edge;
   wire                lvl7_held;
   wire                any_req;

   // Highest set level, zero when none
   function automatic irqrec_lvl_t irqrec_encode(input logic [LEVELS-1:0] v);
      irqrec_lvl_t r;
      r = '0;
      for (int i = 0; i < LEVELS; i++) begin
         if (v[i]) begin
            r = irqrec_lvl_t'(i + 1);
         end
      end
      return r;
   endfunction

   irqrec_pin_filter u_filter (
      .sys_clk_i                   (sys_clk_i),
      .rst_b_i                     (rst_b_i),
      .level_six_request_pin_b_i   (level_six_request_pin_b_i),
      .nonmaskable_request_pin_b_i (nonmaskable_request_pin_b_i),
      .req                         (req.filt)
   );

   // Internal lines qualified separately; pins are never driven back
   always_ff @(negedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         int_hist0_q <= '0;
         int_hist1_q <= '0;
      end else begin
         int_hist0_q <= ~lowest_level_request_b_i;
         int_hist1_q <= int_hist0_q;
      end
   end
   assign int_valid = int_hist0_q & int_hist1_q;

   // Internal level seven is edge qualified like the pin, so a held line fires once
   always_ff @(negedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         int7_seen_q <= 1'b0;
      end else begin
         int7_seen_q <= int_valid[LEVELS-1];
      end
   end
   assign int7_edge = int_valid[LEVELS-1] & ~int7_seen_q;

   // Wired combination of internal and pin sources, level seven kept apart
   assign merged = {1'b0, int_valid[5] | req.lvl6_valid, int_valid[4:0]};

   // Levels one to six survive only above the mask; level seven is never masked; mask zero lets all through
   genvar g;
   generate
      for (g = 0; g < LEVELS - 1; g++) begin : g_mask
         assign unmasked[g] = merged[g] & (irqrec_lvl_t'(g + 1) > mask_q);
      end
   endgenerate
   assign unmasked[LEVELS-1] = nmi_latch_q;

   // Mask leaving all ones while level seven still held re-arms it
   assign lvl7_held     = req.nmi_level | int_valid[LEVELS-1];
   assign nmi_mask_drop = (mask_q == `IRQREC_MASK_RESET) & (mask_d != `IRQREC_MASK_RESET)
                          & lvl7_held;
   assign nmi_set       = req.nmi_edge | nmi_mask_drop | int7_edge;
   assign take          = (state_q == IRQREC_PEND) & boundary_i;
   assign best_lvl      = irqrec_encode(unmasked);
   // Shared test for any unmasked request
   assign any_req       = (best_lvl != '0);
   assign new_mask      = mask_wr_i ? mask_wr_val_i : mask_q;

   always_comb begin
      state_d     = state_q;
      mask_d      = new_mask;
      nmi_latch_d = nmi_latch_q;
      case (state_q)
         IRQREC_IDLE: begin
            if (best_lvl != '0) begin
               state_d = IRQREC_PEND;
            end
         end
         IRQREC_PEND: begin
            if (best_lvl == '0) begin
               state_d = IRQREC_IDLE;
            end else if (take) begin
               state_d = IRQREC_ACK;
               mask_d  = best_lvl;
               if (best_lvl == `IRQREC_LVL_NMI) begin
                  nmi_latch_d = 1'b0;
               end
            end
         end
         IRQREC_ACK: begin
            if (ack_done_i) begin
               state_d = IRQREC_IDLE;
            end
         end
         default: state_d = IRQREC_IDLE;
      endcase
      // A new event beats the clear taken in the same cycle
      if (nmi_set) begin
         nmi_latch_d = 1'b1;
      end
   end

   // State register
   always_ff @(negedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= IRQREC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // All ones out of reset, so only level seven is taken before software lowers it
   always_ff @(negedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mask_q <= `IRQREC_MASK_RESET;
      end else begin
         mask_q <= mask_d;
      end
   end

   // Level-seven event latch, cleared only by taking it
   always_ff @(negedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nmi_latch_q <= 1'b0;
      end else begin
         nmi_latch_q <= nmi_latch_d;
      end
   end

   // Acknowledged level kept for the address and vector outputs
   always_ff @(negedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_lvl_q <= '0;
      end else if (take && any_req) begin
         ack_lvl_q <= best_lvl;
      end
   end

   // Pending level follows the live requests, so nothing is frozen
   assign pending_o                 = (state_q == IRQREC_PEND) & any_req;
   assign pending_lvl_o             = best_lvl;
   assign ack_active_o              = (state_q == IRQREC_ACK);
   assign ack_addr_o                = ack_active_o ? ack_lvl_q : '0;
   // Autovector per level; the 200 assignable numbers come from the source
   assign autovec_o                 = `IRQREC_AUTOVEC_BASE + irqrec_vec_t'(ack_lvl_q);
   // Low condition code bits are the core's flags, not kept here; they read as zero
   assign cc_low                    = 5'h00;
   assign condition_code_register_o = {mask_q, cc_low};
   assign priority_mask_field_o     = mask_q;
endmodule // irqrec_top

/* File: irqrec_consts.svh */
// Constants of the interrupt request recognition block
`ifndef IRQREC_CONSTS_SVH
`define IRQREC_CONSTS_SVH
`define IRQREC_LEVELS        7
`define IRQREC_LVL_W         3
`define IRQREC_MASK_MSB      7
`define IRQREC_MASK_LSB      5
`define IRQREC_MASK_RESET    3'h7
`define IRQREC_LVL_NMI       3'h7
`define IRQREC_LVL_SIX       3'h6
`define IRQREC_SAMPLES       2
`define IRQREC_AUTOVEC_BASE  8'h18
`define IRQREC_USER_VEC_NUM  200
`define IRQREC_ADDR_LVL_MSB  3
`define IRQREC_ADDR_LVL_LSB  1
`endif

/* File: irqrec_pkg.sv */
// Types of the interrupt request recognition block
package irqrec_pkg;
   typedef logic [2:0] irqrec_lvl_t;
   typedef logic [7:0] irqrec_vec_t;
   typedef enum logic [1:0] {IRQREC_IDLE, IRQREC_PEND, IRQREC_ACK} irqrec_state_t;
endpackage

/* File: irqrec_req_if.sv */
// Qualified request levels passed from the pin filter to the recognition core
interface irqrec_req_if;
   logic lvl6_valid;
   logic nmi_level;
   logic nmi_edge;
   modport filt (output lvl6_valid, output nmi_level, output nmi_edge);
   modport core (input lvl6_valid, input nmi_level, input nmi_edge);
endinterface

/* File: irqrec_pin_filter.sv */
// Two-sample qualifier for the two external request pins
`include "irqrec_consts.svh"
module irqrec_pin_filter
   import irqrec_pkg::*;
#(
   parameter int SAMPLES = `IRQREC_SAMPLES
) (
   // Clock and reset
   input  wire logic    sys_clk_i,
   input  wire logic    rst_b_i,
   // Active-low pins
   input  wire logic    level_six_request_pin_b_i,
   input  wire logic    nonmaskable_request_pin_b_i,
   // Qualified requests
   irqrec_req_if.filt   req
);
   logic [SAMPLES-1:0] six_hist_q;
   logic [SAMPLES-1:0] nmi_hist_q;
   logic               nmi_valid_q;
   wire                six_low_all;
   wire                nmi_low_all;

   // Sampled on the falling edge, as the core samples requests
   always_ff @(negedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         six_hist_q  <= '0;
         nmi_hist_q  <= '0;
         nmi_valid_q <= 1'b0;
      end else begin
         six_hist_q  <= {six_hist_q[SAMPLES-2:0], ~level_six_request_pin_b_i};
         nmi_hist_q  <= {nmi_hist_q[SAMPLES-2:0], ~nonmaskable_request_pin_b_i};
         nmi_valid_q <= nmi_low_all;
      end
   end

   assign six_low_all    = &six_hist_q;
   assign nmi_low_all    = &nmi_hist_q;
   assign req.lvl6_valid = six_low_all;
   assign req.nmi_level  = nmi_low_all;
   // Edge plus held level gives one event per assertion
   assign req.nmi_edge   = nmi_low_all & ~nmi_valid_q;
endmodule // irqrec_pin_filter

/* File: irqrec_properties.sv */
// Port checker for the interrupt request recognition block
module irqrec_properties
   import irqrec_pkg::*;
#(parameter int LEVELS = 7) (
   // Inputs of the block
   input wire logic              sys_clk_i,
   input wire logic              rst_b_i,
   input wire logic              level_six_request_pin_b_i,
   input wire logic              nonmaskable_request_pin_b_i,
   input wire logic [LEVELS-1:0] lowest_level_request_b_i,
   input wire logic              boundary_i,
   input wire logic              ack_done_i,
   input wire logic              mask_wr_i,
   input wire irqrec_lvl_t       mask_wr_val_i,
   // Outputs of the block
   input wire logic              pending_o,
   input wire irqrec_lvl_t       pending_lvl_o,
   input wire logic              ack_active_o,
   input wire logic [3:1]        ack_addr_o,
   input wire irqrec_vec_t       autovec_o,
   input wire logic [7:0]        condition_code_register_o,
   input wire irqrec_lvl_t       priority_mask_field_o
);
   default clocking @(negedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_ccr; condition_code_register_o == {priority_mask_field_o, 5'h00}; endproperty
   a_ccr: assert property (p_ccr) else $error("mask not in ccr");
   property p_lvl; pending_o |-> pending_lvl_o > priority_mask_field_o || pending_lvl_o == 3'h7;
   endproperty
   a_lvl: assert property (p_lvl) else $error("masked level pending");
   property p_take; pending_o && boundary_i |=> ack_active_o && ack_addr_o == $past(pending_lvl_o);
   endproperty
   a_take: assert property (p_take) else $error("ack level wrong");
   property p_mask; pending_o && boundary_i |=> priority_mask_field_o == $past(pending_lvl_o);
   endproperty
   a_mask: assert property (p_mask) else $error("mask not loaded");
   property p_vec; ack_active_o |-> autovec_o == 8'h18 + {5'h00, ack_addr_o}; endproperty
   a_vec: assert property (p_vec) else $error("autovector wrong");
   property p_hold; ack_active_o && !ack_done_i |=> ack_active_o; endproperty
   a_hold: assert property (p_hold) else $error("ack dropped early");
   property p_end; ack_active_o && ack_done_i |=> !ack_active_o && ack_addr_o == 3'h0; endproperty
   a_end: assert property (p_end) else $error("ack not ended");
   property p_wait; ack_active_o |-> !pending_o; endproperty
   a_wait: assert property (p_wait) else $error("pending during ack");
   property p_wr; mask_wr_i && !pending_o && !ack_active_o |=>
      priority_mask_field_o == $past(mask_wr_val_i); endproperty
   a_wr: assert property (p_wr) else $error("mask write lost");
endmodule // irqrec_properties
bind irqrec_top irqrec_properties #(.LEVELS(LEVELS)) u_irqrec_properties (.*);

/* File: irqrec_src_model.sv */
// Request sources: internal modules and external devices on wired lines
module irqrec_src_model (
   // Requests wanted, active high
   input  wire logic [6:0] int_req_i,
   input  wire logic       six_a_i,
   input  wire logic       six_b_i,
   input  wire logic       nmi_i,
   // Active-low lines to the block
   output logic [6:0]      int_req_b_o,
   output logic            six_pin_b_o,
   output logic            nmi_pin_b_o
);
   // Every source needs its own nonzero value; the model has one shared ARB_PRIO of 1, and nothing reads it
   localparam logic [3:0] ARB_PRIO = 4'h1;
   // Two devices share the level-six pin
   assign six_pin_b_o = ~(six_a_i | six_b_i);
   assign nmi_pin_b_o = ~nmi_i;
   assign int_req_b_o = ~int_req_i;
endmodule // irqrec_src_model

/* File: irqrec_bench.sv */
// Self-checking bench for the interrupt request recognition block
module irqrec_bench;
   import irqrec_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst_b = 0, bnd = 0, dn = 0, mwr = 0;
   logic        six_a = 0, six_b = 0, nmi = 0, pend, act, six_pb, nmi_pb;
   logic [6:0]  ireq = 0, ireq_b;
   irqrec_lvl_t mval = 0, plvl, msk;
   logic [3:1]  aadr;
   logic [7:0]  avec, condition_code_register;
   int          err_total = 0, cmp_count = 0;
   irqrec_src_model u_irqrec_src_model (.int_req_i(ireq), .six_a_i(six_a), .six_b_i(six_b),
      .nmi_i(nmi), .int_req_b_o(ireq_b), .six_pin_b_o(six_pb), .nmi_pin_b_o(nmi_pb));
   irqrec_top u_irqrec_top (.sys_clk_i(clk), .rst_b_i(rst_b), .level_six_request_pin_b_i(six_pb),
      .nonmaskable_request_pin_b_i(nmi_pb), .lowest_level_request_b_i(ireq_b), .boundary_i(bnd),
      .ack_done_i(dn), .mask_wr_i(mwr), .mask_wr_val_i(mval), .pending_o(pend),
      .pending_lvl_o(plvl), .ack_active_o(act), .ack_addr_o(aadr), .autovec_o(avec),
      .condition_code_register_o(condition_code_register), .priority_mask_field_o(msk));
   initial forever #10 clk = ~clk;
   task automatic cyc(int n); repeat (n) @(posedge clk); endtask
   task chk(logic [7:0] s, logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task mwrite(irqrec_lvl_t v); mwr <= 1; mval <= v; cyc(1); mwr <= 0; cyc(1); endtask
   // Valid after two falling-edge samples, pending one edge later, or two edges later for level seven through its latch
   task pchk(logic p, irqrec_lvl_t l);
      cyc(4);
      chk(pend, p);
      if (p) chk(plvl, l);
   endtask
   task take(irqrec_lvl_t l);
      bnd <= 1; cyc(1); bnd <= 0;
      chk(act, 1);
      chk(aadr, l);
      chk(msk, l);
      chk(avec, 8'h18 + l);
      dn <= 1; ireq <= 0; six_a <= 0; six_b <= 0; cyc(1); dn <= 0; cyc(1);
      chk(act, 0);
   endtask
   task t_reset;
      chk(msk, 7);
      chk(condition_code_register, 8'hE0);
      chk(avec, 8'h18);
      chk(pend, 0);
      $display("test reset done");
   endtask
   task t_six;
      six_a <= 1; pchk(0, 0);
      mwrite(0); pchk(1, 6);
      six_a <= 0; six_b <= 1; pchk(1, 6);
      take(6);
      $display("test six done");
   endtask
   task t_levels;
      for (int l = 1; l < 7; l++) begin
         mwrite(0); ireq[l-1] <= 1; pchk(1, l[2:0]);
         take(l[2:0]);
      end
      $display("test levels done");
   endtask
   task t_over;
      mwrite(0); ireq[1] <= 1; pchk(1, 2);
      ireq[4] <= 1; pchk(1, 5);
      take(5);
      mwrite(3); ireq[2] <= 1; pchk(0, 0);
      ireq[3] <= 1; pchk(1, 4);
      take(4);
      $display("test overtake done");
   endtask
   task t_short;
      mwrite(0); six_a <= 1; cyc(1); six_a <= 0; pchk(0, 0);
      $display("test short done");
   endtask
   task t_nmi;
      mwrite(7); nmi <= 1; pchk(1, 7);
      take(7); pchk(0, 0);
      mwrite(6); pchk(1, 7);
      take(7); nmi <= 0; cyc(2); nmi <= 1; pchk(1, 7);
      take(7); nmi <= 0;
      ireq[6] <= 1; pchk(1, 7);
      take(7); pchk(0, 0);
      $display("test nonmaskable done");
   endtask
   task results;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      cyc(20); rst_b <= 1; cyc(2);
      t_reset; t_six; t_levels; t_over; t_short; t_nmi;
      results;
   end
   // Whole run is about 170 cycles
   initial begin
      cyc(3000); err_total++; results;
   end
endmodule // irqrec_bench
